// ==== logic/acl_pkg.sv ====
// acl_pkg: register map, field layouts, criterion encodings and carriers
// for the single access control entry matcher.
// assumes a 32-bit APB register bus with word-aligned registers.
package acl_pkg;

  // register byte offsets
  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_PROTO    = 12'h004;
  localparam logic [11:0] OFF_SRC_ADDR = 12'h008;
  localparam logic [11:0] OFF_SRC_MASK = 12'h00C;
  localparam logic [11:0] OFF_DST_ADDR = 12'h010;
  localparam logic [11:0] OFF_DST_MASK = 12'h014;
  localparam logic [11:0] OFF_STATUS   = 12'h018;
  localparam logic [11:0] OFF_HIT_CNT  = 12'h01C;

  // control field positions (lsb of each field)
  localparam int CTRL_FTYPE_LSB = 0;
  localparam int CTRL_PROTO_LSB = 2;
  localparam int CTRL_TTL_LSB   = 5;
  localparam int CTRL_FRAG_LSB  = 7;
  localparam int CTRL_OPT_LSB   = 9;
  localparam int CTRL_SRC_LSB   = 11;
  localparam int CTRL_DST_LSB   = 13;
  localparam int CTRL_WIDTH     = 15;

  // reset values
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] PROTO_RESET = 32'h0000_0000;
  localparam logic [31:0] ADDR_RESET  = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET  = 32'hFFFF_FFFF;

  // well-known protocol numbers
  localparam logic [7:0] PROTO_NUM_ICMP = 8'h01;
  localparam logic [7:0] PROTO_NUM_TCP  = 8'h06;
  localparam logic [7:0] PROTO_NUM_UDP  = 8'h11;

  // frame type selection of the entry
  typedef enum logic [1:0] {
    FTYPE_ANY  = 2'h0,
    FTYPE_IPV4 = 2'h1,
    FTYPE_OTHER = 2'h2,
    FTYPE_RSVD = 2'h3
  } ftype_t;

  typedef enum logic [2:0] {
    PROTO_ANY  = 3'h0,
    PROTO_SPEC = 3'h1,
    PROTO_ICMP = 3'h2,
    PROTO_UDP  = 3'h3,
    PROTO_TCP  = 3'h4
  } proto_sel_t;

  // shared by ttl, fragment and option criteria
  typedef enum logic [1:0] {
    TRI_ANY  = 2'h0,
    TRI_NO   = 2'h1,
    TRI_YES  = 2'h2
  } tri_sel_t;

  typedef enum logic [1:0] {
    ADDR_ANY  = 2'h0,
    ADDR_HOST = 2'h1,
    ADDR_NET  = 2'h2
  } addr_sel_t;

  // parsed header fields from the ingress parser
  typedef struct packed {
    logic        is_ipv4;
    logic [7:0]  protocol;
    logic [7:0]  ttl;
    logic        more_frag;
    logic [12:0] frag_offset;
    logic        has_options;
    logic [31:0] source_ipv4_address;
    logic [31:0] destination_ipv4_address;
  } ipv4_hdr_t;

  // per-entry criteria as held in the register file
  typedef struct packed {
    ftype_t      ftype;
    proto_sel_t  proto_sel;
    tri_sel_t    ttl_sel;
    tri_sel_t    frag_sel;
    tri_sel_t    opt_sel;
    addr_sel_t   src_sel;
    addr_sel_t   dst_sel;
    logic [7:0]  proto_val;
    logic [31:0] src_addr;
    logic [31:0] src_mask;
    logic [31:0] dst_addr;
    logic [31:0] dst_mask;
  } ace_cfg_t;

endpackage : acl_pkg

// ==== logic/acl_addr_cmp.sv ====
// acl_addr_cmp: one ipv4 address criterion (any, host or network).
// assumes cfg and frame address are stable in the evaluating cycle.
`timescale 1ns/1ns
`default_nettype none
module acl_addr_cmp (
  // criterion
  input  wire acl_pkg::addr_sel_t sel,
  input  wire logic [31:0]        prog_addr,
  input  wire logic [31:0]        prog_mask,
  // frame
  input  wire logic [31:0]        frame_addr,
  // result
  output logic                    match
);

  always_comb begin
    unique case (sel)
      acl_pkg::ADDR_HOST: match = (frame_addr == prog_addr);
      acl_pkg::ADDR_NET:
        match = ((frame_addr & prog_mask) == (prog_addr & prog_mask));
      default: match = 1'b1;
    endcase
  end

endmodule : acl_addr_cmp
`default_nettype wire

// ==== logic/acl_hdr_cmp.sv ====
// acl_hdr_cmp: protocol, ttl, fragment and option criteria of an entry.
// assumes header fields come from same-clock parser logic.
`timescale 1ns/1ns
`default_nettype none
module acl_hdr_cmp (
  // criteria
  input  wire acl_pkg::proto_sel_t proto_sel,
  input  wire logic [7:0]          proto_val,
  input  wire acl_pkg::tri_sel_t   ttl_sel,
  input  wire acl_pkg::tri_sel_t   frag_sel,
  input  wire acl_pkg::tri_sel_t   opt_sel,
  // frame
  input  wire acl_pkg::ipv4_hdr_t  hdr,
  // results
  output logic                     proto_ok,
  output logic                     ttl_ok,
  output logic                     frag_ok,
  output logic                     opt_ok
);

  logic is_frag;
  logic ttl_nz;

  function automatic logic tri_ok(input acl_pkg::tri_sel_t s,
                                  input logic cond);
    unique case (s)
      acl_pkg::TRI_NO:  tri_ok = !cond;
      acl_pkg::TRI_YES: tri_ok = cond;
      default:          tri_ok = 1'b1;
    endcase
  endfunction : tri_ok

  always_comb begin
    is_frag = hdr.more_frag || (hdr.frag_offset != 13'h0000);
    ttl_nz  = (hdr.ttl != 8'h00);
    unique case (proto_sel)
      acl_pkg::PROTO_SPEC: proto_ok = (hdr.protocol == proto_val);
      acl_pkg::PROTO_ICMP:
        proto_ok = (hdr.protocol == acl_pkg::PROTO_NUM_ICMP);
      acl_pkg::PROTO_UDP:
        proto_ok = (hdr.protocol == acl_pkg::PROTO_NUM_UDP);
      acl_pkg::PROTO_TCP:
        proto_ok = (hdr.protocol == acl_pkg::PROTO_NUM_TCP);
      default: proto_ok = 1'b1;
    endcase
    ttl_ok  = tri_ok(ttl_sel, ttl_nz);
    // ttl "no" means the zero criterion: only ttl==0 hits
    frag_ok = tri_ok(frag_sel, is_frag);
    opt_ok  = tri_ok(opt_sel, hdr.has_options);
  end

endmodule : acl_hdr_cmp
`default_nettype wire

// ==== logic/ipv4_acl_entry_matcher.sv ====
// ipv4_acl_entry_matcher: apb-configured single access control entry,
// registered hit decision for each valid parsed ipv4 header.
// assumes parser fields arrive on pclk with a one-cycle valid strobe.
//
// Notes on behaviour
// - ipv4 criteria apply only when the entry's frame type is ipv4
// - protocol don't-care accepts every protocol number
// - protocol specific hits only when protocol equals programmed byte
// - icmp selection hits only icmp frames; type/code checked elsewhere
// - udp selection hits only udp frames; ports checked elsewhere
// - tcp selection hits only tcp frames; ports and flags elsewhere
// - ttl zero criterion rejects frames with ttl above zero
// - ttl non-zero criterion hits ttl above zero, rejects ttl zero
// - fragment no rejects frames with more-fragments or nonzero offset
// - fragment yes hits only fragmented frames
// - options no rejects frames carrying ipv4 options
// - options yes hits only frames carrying ipv4 options
// - source don't-care ignores the source address
// - source host mode needs exact source address equality
// - source network mode compares source under the source mask
// - destination don't-care ignores the destination address
// - destination host mode needs exact destination equality
// - destination network mode compares under the destination mask
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module ipv4_acl_entry_matcher (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // parsed header from ingress parser
  input  wire logic               hdr_valid,
  input  wire acl_pkg::ipv4_hdr_t hdr,
  // match decision
  output logic                    result_valid,
  output logic                    hit
);

  acl_pkg::ace_cfg_t cfg_reg;
  acl_pkg::ace_cfg_t cfg_next;
  logic [31:0]       prdata_reg;
  logic [31:0]       prdata_next;
  logic              pready_reg;
  logic              pready_next;
  logic              pslverr_reg;
  logic              pslverr_next;
  logic              valid_reg;
  logic              valid_next;
  logic              hit_reg;
  logic              hit_next;
  logic              last_hit_reg;
  logic              last_hit_next;
  logic [31:0]       hit_cnt_reg;
  logic [31:0]       hit_cnt_next;

  logic proto_ok;
  logic ttl_ok;
  logic frag_ok;
  logic opt_ok;
  logic src_ok;
  logic dst_ok;
  logic match_now;
  logic acc_phase;
  logic known_addr;
  logic [31:0] ctrl_view;
  logic        wr_phase;
  logic [31:0] rd_word;

  // pack control criteria into the control word image
  function automatic logic [31:0] ctrl_pack(input acl_pkg::ace_cfg_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[acl_pkg::CTRL_FTYPE_LSB +: 2] = c.ftype;
    w[acl_pkg::CTRL_PROTO_LSB +: 3] = c.proto_sel;
    w[acl_pkg::CTRL_TTL_LSB   +: 2] = c.ttl_sel;
    w[acl_pkg::CTRL_FRAG_LSB  +: 2] = c.frag_sel;
    w[acl_pkg::CTRL_OPT_LSB   +: 2] = c.opt_sel;
    w[acl_pkg::CTRL_SRC_LSB   +: 2] = c.src_sel;
    w[acl_pkg::CTRL_DST_LSB   +: 2] = c.dst_sel;
    ctrl_pack = w;
  endfunction : ctrl_pack

  // offset decode shared by the read and write paths
  function automatic logic addr_known(input logic [11:0] a);
    unique case (a)
      acl_pkg::OFF_CTRL,
      acl_pkg::OFF_PROTO,
      acl_pkg::OFF_SRC_ADDR,
      acl_pkg::OFF_SRC_MASK,
      acl_pkg::OFF_DST_ADDR,
      acl_pkg::OFF_DST_MASK,
      acl_pkg::OFF_STATUS,
      acl_pkg::OFF_HIT_CNT: addr_known = 1'b1;
      default:              addr_known = 1'b0;
    endcase
  endfunction : addr_known

  // unpack a control word image into the criteria selections
  function automatic acl_pkg::ace_cfg_t ctrl_unpack(
      input acl_pkg::ace_cfg_t c,
      input logic [31:0]       w);
    acl_pkg::ace_cfg_t r;
    r           = c;
    r.ftype     = acl_pkg::ftype_t'(w[acl_pkg::CTRL_FTYPE_LSB +: 2]);
    r.proto_sel = acl_pkg::proto_sel_t'(w[acl_pkg::CTRL_PROTO_LSB +: 3]);
    r.ttl_sel   = acl_pkg::tri_sel_t'(w[acl_pkg::CTRL_TTL_LSB +: 2]);
    r.frag_sel  = acl_pkg::tri_sel_t'(w[acl_pkg::CTRL_FRAG_LSB +: 2]);
    r.opt_sel   = acl_pkg::tri_sel_t'(w[acl_pkg::CTRL_OPT_LSB +: 2]);
    r.src_sel   = acl_pkg::addr_sel_t'(w[acl_pkg::CTRL_SRC_LSB +: 2]);
    r.dst_sel   = acl_pkg::addr_sel_t'(w[acl_pkg::CTRL_DST_LSB +: 2]);
    ctrl_unpack = r;
  endfunction : ctrl_unpack

  acl_hdr_cmp u_hdr_cmp (
    .proto_sel (cfg_reg.proto_sel),
    .proto_val (cfg_reg.proto_val),
    .ttl_sel   (cfg_reg.ttl_sel),
    .frag_sel  (cfg_reg.frag_sel),
    .opt_sel   (cfg_reg.opt_sel),
    .hdr       (hdr),
    .proto_ok  (proto_ok),
    .ttl_ok    (ttl_ok),
    .frag_ok   (frag_ok),
    .opt_ok    (opt_ok)
  );

  acl_addr_cmp u_src_cmp (
    .sel        (cfg_reg.src_sel),
    .prog_addr  (cfg_reg.src_addr),
    .prog_mask  (cfg_reg.src_mask),
    .frame_addr (hdr.source_ipv4_address),
    .match      (src_ok)
  );

  acl_addr_cmp u_dst_cmp (
    .sel        (cfg_reg.dst_sel),
    .prog_addr  (cfg_reg.dst_addr),
    .prog_mask  (cfg_reg.dst_mask),
    .frame_addr (hdr.destination_ipv4_address),
    .match      (dst_ok)
  );

  // match evaluation
  always_comb begin
    unique case (cfg_reg.ftype)
      acl_pkg::FTYPE_IPV4:
        match_now = hdr.is_ipv4 && proto_ok && ttl_ok && frag_ok
                    && opt_ok && src_ok && dst_ok;
      acl_pkg::FTYPE_ANY: match_now = 1'b1;
      acl_pkg::FTYPE_OTHER: match_now = !hdr.is_ipv4;
      default: match_now = 1'b1;
    endcase
    valid_next    = hdr_valid;
    hit_next      = hdr_valid && match_now;
    last_hit_next = hdr_valid ? match_now : last_hit_reg;
  end

  // synchronous reset as the entry decision path requires
  always_ff @(posedge pclk) begin
    if (!presetn) begin
      valid_reg    <= 1'b0;
      hit_reg      <= 1'b0;
      last_hit_reg <= 1'b0;
    end else begin
      valid_reg    <= valid_next;
      hit_reg      <= hit_next;
      last_hit_reg <= last_hit_next;
    end
  end

  // hit counter: one count per decision that hits
  always_comb begin
    hit_cnt_next = hit_cnt_reg;
    if (hdr_valid && match_now) begin
      hit_cnt_next = hit_cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit_cnt_reg <= 32'h0000_0000;
    end else begin
      hit_cnt_reg <= hit_cnt_next;
    end
  end

  // read multiplexer; unmapped offsets read as zero
  always_comb begin
    ctrl_view = ctrl_pack(cfg_reg);
    unique case (paddr)
      acl_pkg::OFF_CTRL:     rd_word = ctrl_view;
      acl_pkg::OFF_PROTO:    rd_word = {24'h00_0000, cfg_reg.proto_val};
      acl_pkg::OFF_SRC_ADDR: rd_word = cfg_reg.src_addr;
      acl_pkg::OFF_SRC_MASK: rd_word = cfg_reg.src_mask;
      acl_pkg::OFF_DST_ADDR: rd_word = cfg_reg.dst_addr;
      acl_pkg::OFF_DST_MASK: rd_word = cfg_reg.dst_mask;
      acl_pkg::OFF_STATUS:   rd_word = {31'h0000_0000, last_hit_reg};
      acl_pkg::OFF_HIT_CNT:  rd_word = hit_cnt_reg;
      default:               rd_word = 32'h0000_0000;
    endcase
  end

  // apb response: one wait state, answer held for one cycle
  always_comb begin
    acc_phase    = psel && penable && !pready_reg;
    known_addr   = addr_known(paddr);
    prdata_next  = prdata_reg;
    pready_next  = acc_phase;
    pslverr_next = 1'b0;
    if (acc_phase) begin
      prdata_next  = rd_word;
      pslverr_next = !known_addr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // write lands at the edge where the master sees pready high
  always_comb begin
    wr_phase = psel && penable && pready_reg && pwrite;
    cfg_next = cfg_reg;
    if (wr_phase && addr_known(paddr)) begin
      unique case (paddr)
        acl_pkg::OFF_CTRL:     cfg_next = ctrl_unpack(cfg_reg, pwdata);
        acl_pkg::OFF_PROTO:    cfg_next.proto_val = pwdata[7:0];
        acl_pkg::OFF_SRC_ADDR: cfg_next.src_addr  = pwdata;
        acl_pkg::OFF_SRC_MASK: cfg_next.src_mask  = pwdata;
        acl_pkg::OFF_DST_ADDR: cfg_next.dst_addr  = pwdata;
        acl_pkg::OFF_DST_MASK: cfg_next.dst_mask  = pwdata;
        default: cfg_next = cfg_reg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg.ftype     <= acl_pkg::FTYPE_ANY;
      cfg_reg.proto_sel <= acl_pkg::PROTO_ANY;
      cfg_reg.ttl_sel   <= acl_pkg::TRI_ANY;
      cfg_reg.frag_sel  <= acl_pkg::TRI_ANY;
      cfg_reg.opt_sel   <= acl_pkg::TRI_ANY;
      cfg_reg.src_sel   <= acl_pkg::ADDR_ANY;
      cfg_reg.dst_sel   <= acl_pkg::ADDR_ANY;
      cfg_reg.proto_val <= acl_pkg::PROTO_RESET[7:0];
      cfg_reg.src_addr  <= acl_pkg::ADDR_RESET;
      cfg_reg.src_mask  <= acl_pkg::MASK_RESET;
      cfg_reg.dst_addr  <= acl_pkg::ADDR_RESET;
      cfg_reg.dst_mask  <= acl_pkg::MASK_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign result_valid = valid_reg;
  assign hit          = hit_reg;

endmodule : ipv4_acl_entry_matcher
`default_nettype wire

// ==== verif/ipv4_acl_entry_matcher_props.sv ====
// ipv4_acl_entry_matcher_props: port checks of the entry matcher.
// assumes it is bound onto the top module and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module ipv4_acl_entry_matcher_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // decision
  input wire logic hdr_valid,
  input wire logic result_valid,
  input wire logic hit
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_acc;
    psel && penable && !pready;
  endsequence
  sequence s_ans;
    pready ##1 !pready;
  endsequence

  property p_res;
    hdr_valid |=> result_valid;
  endproperty
  property p_nores;
    !hdr_valid |=> !result_valid;
  endproperty
  property p_hit;
    hit |-> result_valid;
  endproperty
  property p_rst;
    $rose(presetn) |-> !result_valid && !hit;
  endproperty
  property p_acc;
    s_acc |=> s_ans;
  endproperty
  property p_idle;
    !psel |=> !pready;
  endproperty
  property p_err;
    pslverr |-> pready;
  endproperty
  property p_cause;
    pready |-> $past(psel && penable);
  endproperty

  a_res: assert property (p_res)
    else $error("no result one cycle after header");
  a_nores: assert property (p_nores)
    else $error("result without header");
  a_hit: assert property (p_hit)
    else $error("hit outside result cycle");
  a_rst: assert property (p_rst)
    else $error("decision not cleared by reset");
  a_acc: assert property (p_acc)
    else $error("access not answered by one-cycle ready");
  a_idle: assert property (p_idle)
    else $error("ready without select");
  a_err: assert property (p_err)
    else $error("error without ready");
  a_cause: assert property (p_cause)
    else $error("ready without access phase");
endmodule : ipv4_acl_entry_matcher_props

bind ipv4_acl_entry_matcher ipv4_acl_entry_matcher_props props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .hdr_valid(hdr_valid),
  .result_valid(result_valid), .hit(hit));
`default_nettype wire

// ==== verif/ingress_parser_model.sv ====
// ingress_parser_model: far-side parser presenting one header per go.
// assumes go and frame change just after a rising pclk edge.
`timescale 1ns/1ns
`default_nettype none
module ingress_parser_model (
  // clock
  input  wire logic               pclk,
  // command
  input  wire logic               go,
  input  wire acl_pkg::ipv4_hdr_t frame,
  // parser output
  output var logic                hdr_valid,
  output var acl_pkg::ipv4_hdr_t  hdr
);
  initial hdr_valid = 1'b0;
  initial hdr = '0;
  // fields are junk outside the valid cycle
  always @(posedge pclk) begin
    hdr_valid <= go;
    hdr       <= go ? frame : ~hdr;
  end
endmodule : ingress_parser_model
`default_nettype wire

// ==== verif/ipv4_acl_entry_matcher_test.sv ====
// ipv4_acl_entry_matcher_test: apb set-up and per-criterion frames.
// assumes the parser model and the checker are compiled beforehand.
`timescale 1ns/1ns
`default_nettype none
module ipv4_acl_entry_matcher_test;
  localparam int PR = acl_pkg::CTRL_PROTO_LSB;
  localparam int TT = acl_pkg::CTRL_TTL_LSB;
  localparam int FR = acl_pkg::CTRL_FRAG_LSB;
  localparam int OP = acl_pkg::CTRL_OPT_LSB;
  localparam int SR = acl_pkg::CTRL_SRC_LSB;
  localparam int DS = acl_pkg::CTRL_DST_LSB;
  logic               pclk = 0, presetn = 0, go = 0;
  logic               psel = 0, penable = 0, pwrite = 0;
  logic [11:0]        paddr = '0;
  logic [31:0]        pwdata = '0, prdata, rd, cnt;
  logic               pready, pslverr, hdr_valid, result_valid, hit, err;
  acl_pkg::ipv4_hdr_t hdr, b, frame = '0;
  int                 n_mismatch = 0, cmp_count = 0;

  always #20 pclk = ~pclk;

  ipv4_acl_entry_matcher uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hdr_valid(hdr_valid), .hdr(hdr),
    .result_valid(result_valid), .hit(hit));
  ingress_parser_model pm (.pclk(pclk), .go(go), .frame(frame),
    .hdr_valid(hdr_valid), .hdr(hdr));

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task chk(input string nm, input logic [31:0] got, input logic [31:0] ex);
    cmp_count++;
    if (got !== ex) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      n_mismatch++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // k picks the header field that v overrides
  task tc(input logic [31:0] c, input int k, input logic [31:0] v,
          input logic e);
    acl_pkg::ipv4_hdr_t h;
    h = b;
    case (k)
      1: h.is_ipv4 = v[0];
      2: h.protocol = v[7:0];
      3: h.ttl = v[7:0];
      4: h.more_frag = v[0];
      5: h.frag_offset = v[12:0];
      6: h.has_options = v[0];
      7: h.source_ipv4_address = v;
      8: h.destination_ipv4_address = v;
      default: ;
    endcase
    apb(1'b1, acl_pkg::OFF_CTRL, c);
    @(posedge pclk);
    go    <= 1'b1;
    frame <= h;
    @(posedge pclk);
    go <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("result_valid", 32'(result_valid), 32'h1);
    chk("hit", 32'(hit), 32'(e));
  endtask : tc

  function automatic logic [31:0] sel(input int lsb, input int v);
    return 32'(acl_pkg::FTYPE_IPV4) | (32'(v) << lsb);
  endfunction : sel

  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    b = '{1'b1, 8'h06, 8'h40, 1'b0, 13'h0000, 1'b0,
          32'h0A00_0001, 32'hC0A8_0105};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, acl_pkg::OFF_CTRL, 32'h0);
    chk("ctrl", rd, acl_pkg::CTRL_RESET);
    apb(1'b0, acl_pkg::OFF_SRC_MASK, 32'h0);
    chk("src_mask", rd, acl_pkg::MASK_RESET);
    apb(1'b1, 12'h020, 32'hFFFF_FFFF);
    chk("slverr", 32'(err), 32'h1);
    apb(1'b0, 12'h020, 32'h0);
    chk("slverr_rd", 32'(err), 32'h1);
    chk("unmapped_rd", rd, 32'h0);
    apb(1'b1, acl_pkg::OFF_STATUS, 32'hFFFF_FFFF);
    chk("ro_slverr", 32'(err), 32'h0);
    apb(1'b1, acl_pkg::OFF_PROTO, 32'h0000_002F);
    apb(1'b0, acl_pkg::OFF_PROTO, 32'h0);
    chk("proto", rd, 32'h0000_002F);
    apb(1'b1, acl_pkg::OFF_SRC_ADDR, 32'h0A00_0001);
    apb(1'b1, acl_pkg::OFF_SRC_MASK, 32'hFFFF_FF00);
    apb(1'b1, acl_pkg::OFF_DST_ADDR, 32'hC0A8_0105);
    apb(1'b1, acl_pkg::OFF_DST_MASK, 32'hFFFF_0000);
    $display("registers test done");
    tc(32'h20, 1, 32'h0, 1'b1);
    tc(sel(0, 0), 1, 32'h0, 1'b0);
    tc(32'h2, 1, 32'h0, 1'b1);
    tc(32'h2, 0, 32'h0, 1'b0);
    apb(1'b0, acl_pkg::OFF_STATUS, 32'h0);
    chk("status_miss", rd, 32'h0);
    apb(1'b0, acl_pkg::OFF_HIT_CNT, 32'h0);
    cnt = rd;
    tc(sel(PR, 0), 2, 32'h9C, 1'b1);
    apb(1'b0, acl_pkg::OFF_HIT_CNT, 32'h0);
    chk("hit_cnt", rd, cnt + 32'h1);
    apb(1'b0, acl_pkg::OFF_STATUS, 32'h0);
    chk("status_hit", rd, 32'h1);
    tc(sel(PR, 1), 2, 32'h2F, 1'b1);
    tc(sel(PR, 1), 2, 32'h2E, 1'b0);
    tc(sel(PR, 2), 2, 32'h01, 1'b1);
    tc(sel(PR, 2), 2, 32'h06, 1'b0);
    tc(sel(PR, 3), 2, 32'h11, 1'b1);
    tc(sel(PR, 3), 2, 32'h06, 1'b0);
    tc(sel(PR, 4), 0, 32'h0, 1'b1);
    tc(sel(PR, 4), 2, 32'h11, 1'b0);
    $display("frame type and protocol test done");
    tc(sel(TT, 1), 3, 32'h0, 1'b1);
    tc(sel(TT, 1), 3, 32'h1, 1'b0);
    tc(sel(TT, 2), 3, 32'h1, 1'b1);
    tc(sel(TT, 2), 3, 32'h0, 1'b0);
    tc(sel(FR, 1), 0, 32'h0, 1'b1);
    tc(sel(FR, 1), 4, 32'h1, 1'b0);
    tc(sel(FR, 1), 5, 32'h1, 1'b0);
    tc(sel(FR, 2), 5, 32'h1FFF, 1'b1);
    tc(sel(FR, 2), 4, 32'h1, 1'b1);
    tc(sel(FR, 2), 0, 32'h0, 1'b0);
    tc(sel(OP, 1), 6, 32'h1, 1'b0);
    tc(sel(OP, 2), 6, 32'h1, 1'b1);
    tc(sel(OP, 2), 0, 32'h0, 1'b0);
    tc(sel(TT, 1) | sel(OP, 1), 0, 32'h0, 1'b0);
    tc(sel(TT, 2) | sel(OP, 1), 0, 32'h0, 1'b1);
    $display("ttl fragment option test done");
    tc(sel(0, 0), 7, 32'h0102_0304, 1'b1);
    tc(sel(SR, 1), 0, 32'h0, 1'b1);
    tc(sel(SR, 1), 7, 32'h0A00_0003, 1'b0);
    tc(sel(SR, 2), 7, 32'h0A00_00FE, 1'b1);
    tc(sel(SR, 2), 7, 32'h0A00_0101, 1'b0);
    tc(sel(0, 0), 8, 32'h0102_0304, 1'b1);
    tc(sel(DS, 1), 0, 32'h0, 1'b1);
    tc(sel(DS, 1), 8, 32'hC0A8_0104, 1'b0);
    tc(sel(DS, 2), 8, 32'hC0A8_FFFF, 1'b1);
    tc(sel(DS, 2), 8, 32'hC0A9_0105, 1'b0);
    $display("address test done");
    tally_and_finish();
  end
endmodule : ipv4_acl_entry_matcher_test
`default_nettype wire
